/* param_store_pkg.sv */
package param_store_pkg;

  // ---------------------------------------------------------------
  // Object addressing and service codes
  // ---------------------------------------------------------------
  localparam logic [7:0] SVC_RESET      = 8'h05;
  localparam logic [7:0] SVC_GET_SINGLE = 8'h0E;
  localparam logic [7:0] SVC_RESTORE    = 8'h0F;
  localparam logic [7:0] SVC_SAVE       = 8'h10;
  localparam logic [7:0] CLASS_POS_SENS = 8'h17;
  localparam logic [7:0] INST_CLASS     = 8'h00;
  localparam logic [7:0] INST_SENSOR    = 8'h01;

  // ---------------------------------------------------------------
  // Attributes and error codes
  // ---------------------------------------------------------------
  localparam logic [7:0] ATTR_RAW_POS    = 8'h70;
  localparam logic [7:0] ATTR_PARAM_BASE = 8'h01;
  localparam logic [7:0] ERR_BAD_SERVICE = 8'h08;
  localparam logic [7:0] ERR_BAD_ATTR    = 8'h14;
  localparam logic [7:0] ERR_BAD_OBJECT  = 8'h16;
  localparam logic [7:0] RSP_OK          = 8'h00;

  // ---------------------------------------------------------------
  // Working parameter layout and factory defaults
  // ---------------------------------------------------------------
  localparam int         NUM_PARAM     = 4;
  localparam int         PARAM_W       = 32;
  localparam int         POS_W         = 16;
  localparam logic [2:0] PARAM_BYTES   = 3'h4;
  localparam logic [2:0] POS_BYTES     = 3'h2;
  localparam logic [NUM_PARAM-1:0][PARAM_W-1:0] PARAM_DEFAULT = {
    32'h0000_0000,  // Total measuring range
    32'h0001_0000,  // Measuring units per span
    32'h0000_0000,  // Scaling control
    32'h0000_0000   // Count direction
  };

endpackage

/* param_store_requester.sv */
`timescale 1ns/100ps
module param_store_requester
  import param_store_pkg::*;
(
  // Clock
  input  wire logic       sys_clk_i,
  // Request side
  output logic            req_valid_o,
  output logic [7:0]      req_service_o,
  output logic [7:0]      req_class_o,
  output logic [7:0]      req_instance_o,
  output logic            req_attr_present_o,
  output logic [7:0]      req_attr_o,
  // Answer side
  input  wire logic       busy_i,
  input  wire logic       rsp_valid_i,
  input  wire logic [7:0] rsp_data_i,
  input  wire logic       rsp_last_i,
  input  wire logic       rsp_err_i
);
  // Gathered answer
  logic [31:0] rx_val;
  logic [2:0]  rx_cnt;
  logic        rx_err;
  logic        rx_ok;
  logic        rx_busy_ok;

  // Idle request lines
  initial begin
    req_valid_o = 1'b0;
    req_service_o = 8'h00;
    req_class_o = 8'h00;
    req_instance_o = 8'h00;
    req_attr_present_o = 1'b0;
    req_attr_o = 8'h00;
  end

  // Hold one request until taken, then gather bytes on consecutive edges
  task automatic issue(input logic [7:0] s, c, i, input logic ap, input logic [7:0] a);
    int n;
    rx_val = 32'h0;
    rx_cnt = 3'h0;
    rx_err = 1'b0;
    rx_ok = 1'b0;
    rx_busy_ok = 1'b1;
    n = 0;
    @(posedge sys_clk_i);
    req_valid_o <= 1'b1;
    req_service_o <= s;
    req_class_o <= c;
    req_instance_o <= i;
    req_attr_present_o <= ap;
    req_attr_o <= a;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (busy_i !== 1'b0 && n < 50);
    // Released fields show inverted values
    req_valid_o <= 1'b0;
    req_service_o <= ~s;
    req_class_o <= ~c;
    req_instance_o <= ~i;
    req_attr_present_o <= ~ap;
    req_attr_o <= ~a;
    if (n >= 50) return;
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk_i);
      if (rsp_valid_i !== 1'b1) break;
      rx_val[8*k +: 8] = rsp_data_i;
      rx_cnt = rx_cnt + 3'h1;
      rx_err = rsp_err_i;
      // Busy stands on every byte but the last
      if (busy_i !== !rsp_last_i) begin
        rx_busy_ok = 1'b0;
      end
      if (rsp_last_i === 1'b1) begin
        rx_ok = 1'b1;
        break;
      end
    end
    // No stray byte after the last one
    if (rx_ok) begin
      @(posedge sys_clk_i);
      if (rsp_valid_i !== 1'b0) begin
        rx_ok = 1'b0;
      end
    end
  endtask
endmodule

/* param_store_service.sv */
`timescale 1ns/100ps
//Behaviour
//- Save service 16 copies all working parameters into non-volatile storage.
//- Restore service 15 reloads working parameters from non-volatile storage.
//- Reset service 5 loads factory defaults into every working parameter.
//- Reset service leaves non-volatile storage untouched.
//- Get single attribute E at class 23 instance 1 returns that attribute.
//- Attribute 70 returns the raw unscaled 16 bit position.
//- Multi-byte response values go out least significant byte first.
//- Completed save, restore or reset answers with a success response.
//- Network parameter writes touch only volatile working storage.
module param_store_service
  import param_store_pkg::*;
(
  // Clock and reset
  input  wire logic                              sys_clk_i,
  input  wire logic                              rst_i,
  // Explicit request
  input  wire logic                              req_valid_i,
  input  wire logic [7:0]                        req_service_i,
  input  wire logic [7:0]                        req_class_i,
  input  wire logic [7:0]                        req_instance_i,
  input  wire logic                              req_attr_present_i,
  input  wire logic [7:0]                        req_attr_i,
  output logic                                   busy_o,
  // Response byte stream
  output logic                                   rsp_valid_o,
  output logic [7:0]                             rsp_data_o,
  output logic                                   rsp_last_o,
  output logic                                   rsp_err_o,
  // Parameter writes from the network
  input  wire logic                              wr_en_i,
  input  wire logic [1:0]                        wr_idx_i,
  input  wire logic [PARAM_W-1:0]                wr_data_i,
  // Sensor side
  input  wire logic [POS_W-1:0]                  position_i,
  output logic [NUM_PARAM-1:0][PARAM_W-1:0]      param_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic {ST_IDLE, ST_SEND} state_t;

  state_t                             state_q, state_d;
  logic [NUM_PARAM-1:0][PARAM_W-1:0]  work_q, work_d;
  logic [NUM_PARAM-1:0][PARAM_W-1:0]  nv_q, nv_d;
  logic [PARAM_W-1:0]                 shift_q, shift_d;
  logic [2:0]                         cnt_q, cnt_d;
  logic                               busy_q, busy_d;
  logic                               rsp_valid_q, rsp_valid_d;
  logic [7:0]                         rsp_data_q, rsp_data_d;
  logic                               rsp_last_q, rsp_last_d;
  logic                               rsp_err_q, rsp_err_d;

  // ---------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------
  logic       req_acc;
  logic       is_store_svc;
  logic       store_addr_ok;
  logic       get_addr_ok;
  logic       attr_is_pos;
  logic       attr_is_param;
  logic [7:0] attr_off;
  logic       save_ok;
  logic       restore_ok;
  logic       reset_ok;
  logic       get_ok;
  logic       bad_req;
  logic [7:0] err_code;

  // Address and attribute checks
  always_comb begin
    req_acc       = req_valid_i && !busy_q;
    is_store_svc  = (req_service_i == SVC_SAVE) || (req_service_i == SVC_RESTORE) ||
                    (req_service_i == SVC_RESET);
    store_addr_ok = (req_class_i == CLASS_POS_SENS) && (req_instance_i == INST_CLASS) &&
                    !req_attr_present_i;
    get_addr_ok   = (req_class_i == CLASS_POS_SENS) && (req_instance_i == INST_SENSOR) &&
                    req_attr_present_i;
    attr_off      = req_attr_i - ATTR_PARAM_BASE;
    attr_is_pos   = (req_attr_i == ATTR_RAW_POS);
    attr_is_param = (req_attr_i >= ATTR_PARAM_BASE) &&
                    (attr_off < 8'(NUM_PARAM));
    save_ok       = req_acc && store_addr_ok && (req_service_i == SVC_SAVE);
    restore_ok    = req_acc && store_addr_ok && (req_service_i == SVC_RESTORE);
    reset_ok      = req_acc && store_addr_ok && (req_service_i == SVC_RESET);
    get_ok        = req_acc && get_addr_ok && (req_service_i == SVC_GET_SINGLE) &&
                    (attr_is_pos || attr_is_param);
    bad_req       = req_acc && !(save_ok || restore_ok || reset_ok || get_ok);
    if (!is_store_svc && (req_service_i != SVC_GET_SINGLE)) begin
      err_code = ERR_BAD_SERVICE;
    end else if (is_store_svc ? !store_addr_ok : !get_addr_ok) begin
      err_code = ERR_BAD_OBJECT;
    end else begin
      err_code = ERR_BAD_ATTR;
    end
  end

  // ---------------------------------------------------------------
  // Parameter storage
  // ---------------------------------------------------------------
  // Restore and reset take priority over a network write in the same cycle
  always_comb begin
    work_d = work_q;
    nv_d   = nv_q;
    if (wr_en_i) begin
      work_d[wr_idx_i] = wr_data_i;
    end
    if (save_ok) begin
      nv_d = work_q;
    end
    if (restore_ok) begin
      work_d = nv_q;
    end
    if (reset_ok) begin
      work_d = PARAM_DEFAULT;
    end
  end

  // Working and non-volatile copies
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      work_q <= PARAM_DEFAULT;
      nv_q   <= PARAM_DEFAULT;
    end else begin
      work_q <= work_d;
      nv_q   <= nv_d;
    end
  end

  // ---------------------------------------------------------------
  // Response sequencer
  // ---------------------------------------------------------------
  // Serialises answers, low byte first
  always_comb begin
    state_d     = state_q;
    shift_d     = shift_q;
    cnt_d       = cnt_q;
    busy_d      = busy_q;
    rsp_valid_d = 1'b0;
    rsp_data_d  = 8'h00;
    rsp_last_d  = 1'b0;
    rsp_err_d   = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (get_ok) begin
          rsp_valid_d = 1'b1;
          if (attr_is_pos) begin
            shift_d = PARAM_W'(position_i) >> 8;
            rsp_data_d = position_i[7:0];
            cnt_d = POS_BYTES - 3'h1;
          end else begin
            shift_d = work_q[attr_off[1:0]] >> 8;
            rsp_data_d = work_q[attr_off[1:0]][7:0];
            cnt_d = PARAM_BYTES - 3'h1;
          end
          busy_d  = 1'b1;
          state_d = ST_SEND;
        end else if (save_ok || restore_ok || reset_ok) begin
          rsp_valid_d = 1'b1;
          rsp_data_d  = RSP_OK;
          rsp_last_d  = 1'b1;
        end else if (bad_req) begin
          rsp_valid_d = 1'b1;
          rsp_data_d  = err_code;
          rsp_last_d  = 1'b1;
          rsp_err_d   = 1'b1;
        end
      end
      ST_SEND: begin
        rsp_valid_d = 1'b1;
        rsp_data_d  = shift_q[7:0];
        shift_d     = shift_q >> 8;
        cnt_d       = cnt_q - 3'h1;
        if (cnt_q == 3'h1) begin
          rsp_last_d = 1'b1;
          busy_d     = 1'b0;
          state_d    = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        busy_d  = 1'b0;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q     <= ST_IDLE;
      shift_q     <= '0;
      cnt_q       <= 3'h0;
      busy_q      <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 8'h00;
      rsp_last_q  <= 1'b0;
      rsp_err_q   <= 1'b0;
    end else begin
      state_q     <= state_d;
      shift_q     <= shift_d;
      cnt_q       <= cnt_d;
      busy_q      <= busy_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q  <= rsp_data_d;
      rsp_last_q  <= rsp_last_d;
      rsp_err_q   <= rsp_err_d;
    end
  end

  // Outputs straight from flops
  assign busy_o      = busy_q;
  assign rsp_valid_o = rsp_valid_q;
  assign rsp_data_o  = rsp_data_q;
  assign rsp_last_o  = rsp_last_q;
  assign rsp_err_o   = rsp_err_q;
  assign param_o     = work_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_save_copy;
    @(posedge sys_clk_i) disable iff (rst_i)
    save_ok |=> nv_q == $past(work_q);
  endproperty
  a_save_copy: assert property (p_save_copy) else $error("save did not copy");

  property p_restore_load;
    @(posedge sys_clk_i) disable iff (rst_i)
    restore_ok |=> work_q == $past(nv_q);
  endproperty
  a_restore_load: assert property (p_restore_load) else $error("restore wrong");

  property p_reset_default;
    @(posedge sys_clk_i) disable iff (rst_i)
    reset_ok |=> work_q == PARAM_DEFAULT;
  endproperty
  a_reset_default: assert property (p_reset_default) else $error("reset wrong");

  property p_reset_keeps_nv;
    @(posedge sys_clk_i) disable iff (rst_i)
    reset_ok |=> $stable(nv_q);
  endproperty
  a_reset_keeps_nv: assert property (p_reset_keeps_nv) else $error("reset wrote nv");

  property p_pos_lsb_first;
    @(posedge sys_clk_i) disable iff (rst_i)
    (get_ok && attr_is_pos) |=> (rsp_valid_q && !rsp_last_q &&
      rsp_data_q == $past(position_i[7:0])) ##1
      (rsp_valid_q && rsp_last_q && rsp_data_q == $past(position_i[15:8], 2));
  endproperty
  a_pos_lsb_first: assert property (p_pos_lsb_first) else $error("position bytes");

  property p_param_get;
    @(posedge sys_clk_i) disable iff (rst_i)
    (get_ok && attr_is_param && attr_off == 8'h02) |=>
      rsp_data_q == $past(work_q[2][7:0]) ##3 (rsp_last_q && !rsp_err_q);
  endproperty
  a_param_get: assert property (p_param_get) else $error("param get wrong");

  property p_ok_answer;
    @(posedge sys_clk_i) disable iff (rst_i)
    (save_ok || restore_ok || reset_ok) |=> rsp_valid_q && rsp_last_q && !rsp_err_q;
  endproperty
  a_ok_answer: assert property (p_ok_answer) else $error("no success reply");

  property p_write_volatile;
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr_en_i && !save_ok) |=> $stable(nv_q);
  endproperty
  a_write_volatile: assert property (p_write_volatile) else $error("write hit nv");

  property p_bad_req;
    @(posedge sys_clk_i) disable iff (rst_i)
    (bad_req && !wr_en_i) |=> rsp_err_q && rsp_last_q && $stable(work_q) && $stable(nv_q);
  endproperty
  a_bad_req: assert property (p_bad_req) else $error("bad request handled");

  property p_nv_whole;
    @(posedge sys_clk_i) disable iff (rst_i)
    !$stable(nv_q) |-> $past(save_ok) && nv_q == $past(work_q);
  endproperty
  a_nv_whole: assert property (p_nv_whole) else $error("nv partial change");

  c_save: cover property (@(posedge sys_clk_i) disable iff (rst_i) save_ok);
  c_get_pos: cover property (@(posedge sys_clk_i) disable iff (rst_i) get_ok && attr_is_pos);
  c_error: cover property (@(posedge sys_clk_i) disable iff (rst_i) bad_req);
  c_restore: cover property (@(posedge sys_clk_i) disable iff (rst_i) restore_ok);

endmodule

/* param_store_service_tb_top.sv */
`timescale 1ns/100ps
module param_store_service_tb_top
  import param_store_pkg::*;
;
  logic                              sys_clk_i, rst_i, busy_o, rsp_valid_o, rsp_last_o;
  logic                              req_valid_i, req_attr_present_i, rsp_err_o, wr_en_i;
  logic [7:0]                        req_service_i, req_class_i, req_instance_i;
  logic [7:0]                        req_attr_i, rsp_data_o;
  logic [1:0]                        wr_idx_i;
  logic [PARAM_W-1:0]                wr_data_i;
  logic [POS_W-1:0]                  position_i;
  logic [NUM_PARAM-1:0][PARAM_W-1:0] param_o, va, vb;
  int                                n_errors, n_checks;

  param_store_service dut_u (
    .sys_clk_i          (sys_clk_i),
    .rst_i              (rst_i),
    .req_valid_i        (req_valid_i),
    .req_service_i      (req_service_i),
    .req_class_i        (req_class_i),
    .req_instance_i     (req_instance_i),
    .req_attr_present_i (req_attr_present_i),
    .req_attr_i         (req_attr_i),
    .busy_o             (busy_o),
    .rsp_valid_o        (rsp_valid_o),
    .rsp_data_o         (rsp_data_o),
    .rsp_last_o         (rsp_last_o),
    .rsp_err_o          (rsp_err_o),
    .wr_en_i            (wr_en_i),
    .wr_idx_i           (wr_idx_i),
    .wr_data_i          (wr_data_i),
    .position_i         (position_i),
    .param_o            (param_o)
  );
  param_store_requester req_u (.sys_clk_i(sys_clk_i), .req_valid_o(req_valid_i),
    .req_service_o(req_service_i), .req_class_o(req_class_i),
    .req_instance_o(req_instance_i), .req_attr_present_o(req_attr_present_i),
    .req_attr_o(req_attr_i), .busy_i(busy_o), .rsp_valid_i(rsp_valid_o),
    .rsp_data_i(rsp_data_o), .rsp_last_i(rsp_last_o), .rsp_err_i(rsp_err_o));

  // Clock
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // Closing report
  task automatic print_verdict();
    if (n_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [127:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // One request and the full answer judged
  task automatic svc(input logic [7:0] s, c, i, input logic ap, input logic [7:0] a,
                     input logic er, input logic [2:0] n, input logic [31:0] v);
    req_u.issue(s, c, i, ap, a);
    chk("answer complete", 1'b1, req_u.rx_ok);
    chk("answer bytes", n, req_u.rx_cnt);
    chk("answer error", er, req_u.rx_err);
    chk("answer value", v, req_u.rx_val);
    chk("busy during answer", 1'b1, req_u.rx_busy_ok);
  endtask

  task automatic wr_all(input logic [NUM_PARAM-1:0][PARAM_W-1:0] v);
    for (int k = 0; k < NUM_PARAM; k++) begin
      @(posedge sys_clk_i);
      wr_en_i <= 1'b1;
      wr_idx_i <= 2'(k);
      wr_data_i <= v[k];
      @(posedge sys_clk_i);
      wr_en_i <= 1'b0;
    end
    @(posedge sys_clk_i);
    chk("param after writes", v, param_o);
  endtask

  task automatic t_save_restore();
    wr_all(va);
    svc(SVC_SAVE, CLASS_POS_SENS, INST_CLASS, 1'b0, 8'h00, 1'b0, 3'h1, 32'(RSP_OK));
    wr_all(vb);
    svc(SVC_RESTORE, CLASS_POS_SENS, INST_CLASS, 1'b0, 8'h00, 1'b0, 3'h1, 32'(RSP_OK));
    chk("param after restore", va, param_o);
  endtask

  task automatic t_reset_svc();
    svc(SVC_RESET, CLASS_POS_SENS, INST_CLASS, 1'b0, 8'h00, 1'b0, 3'h1, 32'(RSP_OK));
    chk("param after reset service", PARAM_DEFAULT, param_o);
    svc(SVC_RESTORE, CLASS_POS_SENS, INST_CLASS, 1'b0, 8'h00, 1'b0, 3'h1, 32'(RSP_OK));
    chk("stored copy after reset service", va, param_o);
  endtask

  task automatic t_get();
    position_i <= 16'hA53C;
    svc(SVC_GET_SINGLE, CLASS_POS_SENS, INST_SENSOR, 1'b1, ATTR_RAW_POS, 1'b0, POS_BYTES,
        32'h0000_A53C);
    for (int k = 0; k < NUM_PARAM; k++) begin
      svc(SVC_GET_SINGLE, CLASS_POS_SENS, INST_SENSOR, 1'b1, ATTR_PARAM_BASE + 8'(k), 1'b0,
          PARAM_BYTES, va[k]);
    end
  endtask

  task automatic t_errors();
    logic [7:0] es[5] = '{8'h4B, SVC_SAVE, SVC_RESTORE, SVC_RESET, SVC_GET_SINGLE};
    logic [7:0] ec[5] = '{CLASS_POS_SENS, 8'h18, CLASS_POS_SENS, CLASS_POS_SENS, CLASS_POS_SENS};
    logic [7:0] ei[5] = '{INST_SENSOR, INST_CLASS, INST_SENSOR, INST_CLASS, INST_SENSOR};
    logic       ep[5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    logic [7:0] ek[5] = '{ERR_BAD_SERVICE, ERR_BAD_OBJECT, ERR_BAD_OBJECT, ERR_BAD_OBJECT,
                          ERR_BAD_ATTR};
    wr_all(vb);
    for (int k = 0; k < 5; k++) begin
      svc(es[k], ec[k], ei[k], ep[k], 8'h71, 1'b1, 3'h1, 32'(ek[k]));
      chk("param after refused request", vb, param_o);
    end
    svc(SVC_RESTORE, CLASS_POS_SENS, INST_CLASS, 1'b0, 8'h00, 1'b0, 3'h1, 32'(RSP_OK));
    chk("stored copy after refused requests", va, param_o);
  endtask

  task automatic t_power();
    wr_all(vb);
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    chk("param after power cycle", PARAM_DEFAULT, param_o);
  endtask

  // Watchdog
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    n_errors++;
    print_verdict();
  end

  // Main sequence
  initial begin
    n_errors = 0;
    n_checks = 0;
    rst_i = 1'b1;
    wr_en_i = 1'b0;
    wr_idx_i = 2'h0;
    wr_data_i = 32'h0;
    position_i = 16'h0000;
    va = {32'h0000_1FFF, 32'h0000_2000, 32'h0000_0001, 32'h0000_0001};
    vb = {32'h1234_5678, 32'h00FF_00FF, 32'h8000_0000, 32'hDEAD_BEEF};
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    chk("param at reset", PARAM_DEFAULT, param_o);
    t_save_restore();
    t_reset_svc();
    t_get();
    t_errors();
    t_power();
    print_verdict();
  end
endmodule
